// [tb/cpes_top_asserts.sv]
`timescale 1ns/1ps
module cpes_top_asserts #(
  parameter SWITCH_CYCLES = 16
) (
  input wire        I_CLK_SYS,
  input wire        I_ARST_N,
  input wire        I_WB_CYC,
  input wire        I_WB_STB,
  input wire        I_WB_WE,
  input wire [7:0]  I_WB_ADR,
  input wire [3:0]  I_WB_SEL,
  input wire [31:0] I_WB_DAT,
  input wire [31:0] O_WB_DAT,
  input wire        O_WB_ACK,
  input wire        I_FUSE_LOAD,
  input wire        O_SLOW_XTAL_ON,
  input wire [9:0]  O_RC_TRIM,
  input wire        O_IRQ
);
  // ==========================================================
  // Shadow of the enable mask and of the clock switch wait
  localparam [7:0] SW_LOAD = SWITCH_CYCLES + 2;
  wire        wr      = I_WB_CYC && I_WB_STB && !O_WB_ACK && I_WB_WE;
  wire        rd_ack  = O_WB_ACK && !I_WB_WE;
  wire        wr_trim = wr && I_WB_ADR == 8'hC0;
  wire [31:0] bm      = {{8{I_WB_SEL[3]}}, {8{I_WB_SEL[2]}}, {8{I_WB_SEL[1]}}, {8{I_WB_SEL[0]}}};
  reg  [31:0] msk_reg;
  reg  [7:0]  sw_reg;
  reg         sw_seen_reg;
  always @(posedge I_CLK_SYS or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      msk_reg     <= 32'h0;
      sw_reg      <= 8'h0;
      sw_seen_reg <= 1'b0;
    end else begin
      if (wr && I_WB_ADR == 8'h40)
        msk_reg <= msk_reg | (I_WB_DAT & bm & 32'h000103E3);
      else if (wr && I_WB_ADR == 8'h44)
        msk_reg <= msk_reg & ~(I_WB_DAT & bm);
      // Two extra cycles cover the live_reg and rdat_reg stages, so the high check lands on the exact switch edge.
      if (wr && I_WB_ADR == 8'h00) begin
        sw_reg      <= SW_LOAD;
        sw_seen_reg <= 1'b1;
      end else if (sw_reg != 8'h0)
        sw_reg <= sw_reg - 8'h01;
    end
  end
  // ==========================================================
  // Properties
  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (!I_ARST_N);
  ack_pulse_a: assert property (O_WB_ACK |=> !O_WB_ACK)
    else $error("ack held longer than one cycle");
  ack_one_a: assert property (I_WB_CYC && I_WB_STB && !O_WB_ACK |=> O_WB_ACK)
    else $error("ack missing one cycle after request");
  idle_data_a: assert property (!O_WB_ACK |-> O_WB_DAT == 32'h0)
    else $error("read data not zero outside ack");
  mask_view_a: assert property (rd_ack && I_WB_ADR == 8'h48 |-> O_WB_DAT == msk_reg)
    else $error("enable mask read differs from written history");
  wo_zero_a: assert property (rd_ack && (I_WB_ADR == 8'h40 || I_WB_ADR == 8'h44
    || I_WB_ADR == 8'h50) |-> O_WB_DAT == 32'h0) else $error("write-only register read not zero");
  irq_mask_a: assert property (O_IRQ |-> msk_reg != 32'h0)
    else $error("interrupt request with no source enabled");
  slow_on_a: assert property (wr && I_WB_ADR == 8'h30 && I_WB_SEL[0]
    |=> O_SLOW_XTAL_ON == $past(I_WB_DAT[0])) else $error("slow crystal enable wrong");
  switch_low_a: assert property (rd_ack && I_WB_ADR == 8'h4C && sw_reg > 8'h04
    |-> !O_WB_DAT[5]) else $error("switch done read one too early");
  switch_high_a: assert property (rd_ack && I_WB_ADR == 8'h4C && sw_seen_reg
    && sw_reg == 8'h0 |-> O_WB_DAT[5]) else $error("switch done not one after wait");
  trim_hold_a: assert property ($changed(O_RC_TRIM) |-> $past(I_FUSE_LOAD) || $past(wr_trim))
    else $error("trim changed without load or write");
  cover property (O_IRQ);
  cover property (rd_ack && I_WB_ADR == 8'h4C && O_WB_DAT[5]);
  cover property (wr_trim);
endmodule

// [tb/tb_clock_power_event_status.sv]
`timescale 1ns/1ps
module tb_clock_power_event_status;
  // ==========================================================
  // Signals
  logic        clk, arst_n, cyc, stb, we, fload, ack, irq, slow_on;
  logic        bo, xa, xb, sx, pa, pb, slow;
  logic [3:0]  sel, src;
  logic [7:0]  adr;
  logic [9:0]  ftrim, trim;
  logic [10:0] div_cnt;
  logic [4:0]  gclk;
  logic [31:0] dat_w, dat_r, main_ch, clk_msk, lfsr, r, m, ev, cv;
  logic [31:0] exp_q[$], care_q[$];
  // Live status and flags are read first, before the settle timers started by reset end.
  logic [7:0]  ra[0:8] = '{8'h54, 8'h4C, 8'h40, 8'h44, 8'h48, 8'h50, 8'h60, 8'h30, 8'hFC};
  logic [31:0] rv[0:8] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h00010000, 32'h0};
  int          n_mismatch, compares, cyc_cnt, k;
  cpes_top #(.NUM_GCLK(5), .SWITCH_CYCLES(16), .MASK_CYCLES(8)) u_dut (
    .I_CLK_SYS(clk), .I_ARST_N(arst_n), .I_WB_CYC(cyc), .I_WB_STB(stb), .I_WB_WE(we),
    .I_WB_ADR(adr), .I_WB_SEL(sel), .I_WB_DAT(dat_w), .O_WB_DAT(dat_r), .O_WB_ACK(ack),
    .I_BROWNOUT_RAW(bo), .I_XTAL_A_RAW(xa), .I_XTAL_B_RAW(xb), .I_SLOW_XTAL_RAW(sx),
    .I_PLL_A_RAW(pa), .I_PLL_B_RAW(pb), .I_SLOW_CLK(slow), .I_GCLK_SRC(src),
    .I_FUSE_LOAD(fload), .I_FUSE_TRIM(ftrim), .O_SLOW_XTAL_ON(slow_on),
    .O_MAIN_CLOCK_CHOICE(main_ch), .O_CLOCK_MASK(clk_msk), .O_RC_TRIM(trim), .O_GCLK(gclk),
    .O_IRQ(irq));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // ==========================================================
  // Helpers
  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction
  task chk32(input logic [31:0] got, input logic [31:0] expv);
    compares++;
    if (got !== expv) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, expv);
    end
  endtask
  task chk1(input logic got, input logic expv);
    chk32({31'h0, got}, {31'h0, expv});
  endtask
  task results;
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // A read notes its expected word and care mask; the monitor compares at ack.
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] c);
    if (!w) begin
      exp_q.push_back(d);
      care_q.push_back(c);
    end
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'hF;
    dat_w <= w ? d : 32'h0;
    // Only the bench timeout may end a wait for the answer.
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk);
  endtask
  // Counts rising edges of one generic clock over a fixed window.
  task gcount(input logic [7:0] a, input int g, input logic [31:0] c, input int lo, input int hi);
    int n;
    logic p;
    wb(1'b1, a, c, 32'h0);
    repeat (64) @(posedge clk);
    n = 0;
    p = gclk[g];
    repeat (1024) begin
      @(posedge clk);
      if (gclk[g] && !p)
        n++;
      p = gclk[g];
    end
    chk1(n >= lo && n <= hi, 1'b1);
  endtask
  always @(posedge clk) begin
    if (ack === 1'b1 && we === 1'b0) begin
      ev = exp_q.pop_front();
      cv = care_q.pop_front();
      chk32(dat_r & cv, ev & cv);
    end
  end
  // Sources are slow divisions of the system clock; the run is cut short on a hang.
  always @(posedge clk) begin
    div_cnt <= div_cnt + 11'h001;
    src <= div_cnt[6:3];
    slow <= div_cnt[2];
    cyc_cnt++;
    if (cyc_cnt == 30000) begin
      n_mismatch++;
      results();
    end
  end
  // ==========================================================
  // Main sequence
  initial begin
    {cyc, stb, we, fload, bo, xa, xb, sx, pa, pb, slow} = 11'h000;
    {adr, sel, src, dat_w, ftrim, div_cnt} = '0;
    lfsr = 32'h877a;
    n_mismatch = 0;
    compares = 0;
    cyc_cnt = 0;
    arst_n = 1'b0;
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    for (k = 0; k < 9; k++)
      wb(1'b0, ra[k], rv[k], 32'hFFFFFFFF);
    m = 32'h0;
    repeat (6) begin
      r = rnd();
      wb(1'b1, 8'h40, r, 32'h0);
      m = m | (r & 32'h000103E3);
      r = rnd() & rnd();
      wb(1'b1, 8'h44, r, 32'h0);
      m = m & ~r;
      wb(1'b0, 8'h48, m, 32'hFFFFFFFF);
    end
    wb(1'b1, 8'h44, 32'hFFFFFFFF, 32'h0);
    r = rnd();
    wb(1'b1, 8'h00, r, 32'h0);
    chk32(main_ch, r);
    wb(1'b1, 8'h50, 32'h00000020, 32'h0);
    wb(1'b0, 8'h4C, 32'h0, 32'h00000020);
    repeat (20) @(posedge clk);
    wb(1'b1, 8'h50, 32'h00000020, 32'h0);
    wb(1'b0, 8'h4C, 32'h00000020, 32'h00000020);
    wb(1'b1, 8'h50, 32'h00000040, 32'h0);
    r = rnd();
    wb(1'b1, 8'h08, r, 32'h0);
    chk32(clk_msk, r);
    wb(1'b0, 8'h4C, 32'h0, 32'h00000040);
    wb(1'b0, 8'h54, 32'h0, 32'h00000040);
    repeat (12) @(posedge clk);
    wb(1'b0, 8'h54, 32'h00000040, 32'h00000040);
    wb(1'b0, 8'h4C, 32'h00000040, 32'h00000040);
    sx <= 1'b1;
    wb(1'b1, 8'h30, 32'h00000000, 32'h0);
    chk1(slow_on, 1'b0);
    repeat (5) @(posedge clk);
    wb(1'b0, 8'h54, 32'h0, 32'h00000200);
    wb(1'b1, 8'h50, 32'hFFFFFFFF, 32'h0);
    wb(1'b1, 8'h30, 32'h00000001, 32'h0);
    chk1(slow_on, 1'b1);
    {bo, xa, xb, pa, pb} <= 5'h1F;
    repeat (5) @(posedge clk);
    wb(1'b1, 8'h20, 32'h03000001, 32'h0);
    wb(1'b1, 8'h24, 32'h03000001, 32'h0);
    wb(1'b0, 8'h54, 32'h0, 32'h00000003);
    repeat (60) @(posedge clk);
    wb(1'b0, 8'h54, 32'h00010383, 32'h00010383);
    wb(1'b0, 8'h4C, 32'h00010383, 32'h00010383);
    chk1(irq, 1'b0);
    wb(1'b1, 8'h40, 32'h00010000, 32'h0);
    chk1(irq, 1'b1);
    bo <= 1'b0;
    repeat (6) @(posedge clk);
    wb(1'b0, 8'h54, 32'h0, 32'h00010000);
    wb(1'b0, 8'h4C, 32'h00010000, 32'h00010000);
    wb(1'b1, 8'h50, 32'h00010000, 32'h0);
    chk1(irq, 1'b0);
    wb(1'b0, 8'h4C, 32'h00000383, 32'h00010383);
    r = rnd();
    ftrim <= r[9:0];
    fload <= 1'b1;
    @(posedge clk);
    fload <= 1'b0;
    @(posedge clk);
    chk32({22'h0, trim}, {22'h0, r[9:0]});
    wb(1'b0, 8'hC0, {15'h0, 1'b1, 6'h0, r[9:0]}, 32'h000103FF);
    ftrim <= ~r[9:0];
    fload <= 1'b1;
    @(posedge clk);
    fload <= 1'b0;
    @(posedge clk);
    chk32({22'h0, trim}, {22'h0, r[9:0]});
    wb(1'b1, 8'hC0, 32'h55000000, 32'h0);
    wb(1'b1, 8'hC0, 32'hAA0102A5, 32'h0);
    chk32({22'h0, trim}, 32'h000002A5);
    wb(1'b1, 8'hC0, 32'hAA01015A, 32'h0);
    chk32({22'h0, trim}, 32'h000002A5);
    wb(1'b0, 8'hC0, 32'h000102A5, 32'h000103FF);
    for (k = 0; k < 4; k++)
      gcount(8'h60, 0, 32'h4 | k, (64 >> k) - 1, (64 >> k) + 1);
    gcount(8'h64, 1, 32'h00000114, 15, 17);
    gcount(8'h60, 0, 32'h00000010, 0, 0);
    wb(1'b0, 8'h64, 32'h00000114, 32'hFFFFFFFF);
    wb(1'b0, 8'h60, 32'h00000010, 32'hFFFFFFFF);
    arst_n <= 1'b0;
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    wb(1'b0, 8'h48, 32'h0, 32'hFFFFFFFF);
    results();
  end
endmodule
bind cpes_top cpes_top_asserts #(.SWITCH_CYCLES(SWITCH_CYCLES)) u_chk (
  .I_CLK_SYS(I_CLK_SYS), .I_ARST_N(I_ARST_N), .I_WB_CYC(I_WB_CYC), .I_WB_STB(I_WB_STB),
  .I_WB_WE(I_WB_WE), .I_WB_ADR(I_WB_ADR), .I_WB_SEL(I_WB_SEL), .I_WB_DAT(I_WB_DAT),
  .O_WB_DAT(O_WB_DAT), .O_WB_ACK(O_WB_ACK), .I_FUSE_LOAD(I_FUSE_LOAD),
  .O_SLOW_XTAL_ON(O_SLOW_XTAL_ON), .O_RC_TRIM(O_RC_TRIM), .O_IRQ(O_IRQ));

// [verilog/cpes_consts.vh]
`ifndef CPES_CONSTS_VH
`define CPES_CONSTS_VH

// ==================================================================
// Register byte offsets
`define CPES_OFS_MAIN_CLK     8'h00
`define CPES_OFS_CLK_MASK     8'h08
`define CPES_OFS_PLL_A        8'h20
`define CPES_OFS_PLL_B        8'h24
`define CPES_OFS_SLOW_XTAL    8'h30
`define CPES_OFS_EN_SET       8'h40
`define CPES_OFS_EN_CLR       8'h44
`define CPES_OFS_EN_MASK      8'h48
`define CPES_OFS_FLAGS        8'h4C
`define CPES_OFS_ACK          8'h50
`define CPES_OFS_LIVE         8'h54
`define CPES_OFS_GCLK_FIRST   8'h60
`define CPES_OFS_RC_TRIM      8'hC0

// ==================================================================
// Event bit positions
`define CPES_BIT_PLL_A        0
`define CPES_BIT_PLL_B        1
`define CPES_BIT_SWITCH       5
`define CPES_BIT_GATING       6
`define CPES_BIT_XTAL_A       7
`define CPES_BIT_XTAL_B       8
`define CPES_BIT_SLOW         9
`define CPES_BIT_BROWNOUT     16
`define CPES_EVT_BITS         32'h000103E3

// ==================================================================
// Field positions and reset values
`define CPES_PLL_EN_BIT       0
`define CPES_PLL_CNT_HI       29
`define CPES_PLL_CNT_LO       24
`define CPES_PLL_RW_BITS      32'h3F0F3F3F
`define CPES_SLOW_ON_BIT      0
`define CPES_SLOW_RW_BITS     32'h00070701
`define CPES_SLOW_RESET       32'h00010000
`define CPES_MAIN_RW_BITS     32'hFFFFFFFF
`define CPES_MASK_RW_BITS     32'hFFFFFFFF
`define CPES_GCLK_RW_BITS     32'h0000FF17
`define CPES_GCLK_DIV_HI      15
`define CPES_GCLK_DIV_LO      8
`define CPES_GCLK_RATIO_APPLY_BIT   4
`define CPES_GCLK_RUN_BIT     2
`define CPES_GCLK_KIND_BIT    1
`define CPES_GCLK_INDEX_BIT   0
`define CPES_KEY_HI           31
`define CPES_KEY_LO           24
`define CPES_KEY_FIRST        8'h55
`define CPES_KEY_SECOND       8'hAA
`define CPES_FUSE_DONE_BIT    16
`define CPES_TRIM_HI          9
`define CPES_TRIM_LO          0
`define CPES_ZERO32           32'h00000000

`endif

// [verilog/cpes_gclk_div.v]
`timescale 1ns/1ps
`include "cpes_consts.vh"

module cpes_gclk_div (
  // Clock and reset
  input  wire        i_clk,
  input  wire        i_arst_n,
  // Synchronised sources: osc a, osc b, pll a, pll b
  input  wire [3:0]  i_src,
  // Control word
  input  wire [31:0] i_ctrl,
  // Generic clock
  output wire        o_gclk
);

  reg  [7:0] cnt_reg;
  reg        out_reg;
  reg        prev_reg;
  wire [1:0] pick;
  wire       src_lvl;
  wire       rise;
  wire [7:0] ratio;

  // ================================================================
  // Source choice
  assign pick    = {i_ctrl[`CPES_GCLK_KIND_BIT], i_ctrl[`CPES_GCLK_INDEX_BIT]};
  assign src_lvl = i_src[pick];
  assign rise    = src_lvl & ~prev_reg;
  assign ratio   = i_ctrl[`CPES_GCLK_DIV_HI:`CPES_GCLK_DIV_LO];
  assign o_gclk  = out_reg;

  // ================================================================
  // Divider
  // A toggle every ratio+1 source rises gives a period of 2*(ratio+1).
  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cnt_reg  <= 8'h00;
      out_reg  <= 1'b0;
      prev_reg <= 1'b0;
    end else begin
      prev_reg <= src_lvl;
      if (!i_ctrl[`CPES_GCLK_RUN_BIT]) begin
        cnt_reg <= 8'h00;
        out_reg <= 1'b0;
      end else if (!i_ctrl[`CPES_GCLK_RATIO_APPLY_BIT]) begin
        cnt_reg <= 8'h00;
        out_reg <= src_lvl;
      end else if (rise) begin
        if (cnt_reg >= ratio) begin
          cnt_reg <= 8'h00;
          out_reg <= ~out_reg;
        end else begin
          cnt_reg <= cnt_reg + 8'h01;
        end
      end
    end
  end

endmodule

// [verilog/cpes_top.v]
// Behaviour
// - Ones written to enable-set set matching mask bits; zeros leave them.
// - Ones written to enable-clear clear matching mask bits; zeros leave them.
// - Mask register reads enabled sources as one; resets to zero.
// - Ones written to acknowledge clear matching flag bits; zeros do nothing.
// - Brownout flag bit 16 sets on a rise of live brownout status.
// - Slow crystal flag bit 9 sets on a rise of its live ready.
// - Crystal b flag bit 8 sets on a rise of its live ready.
// - Crystal a flag bit 7 sets on a rise of its live ready.
// - Gating flag bit 6 sets when live gating-settled status rises.
// - Switch-done bit 5 reads zero after main clock write until effective.
// - Acknowledging bit 5 leaves the switch-done flag unchanged.
// - PLL b flag bit 1 sets on a rise of its live lock.
// - PLL a flag bit 0 sets on a rise of its live lock.
// - Live status shows brownout detector level directly; resets to zero.
// - Live oscillator ready reads zero while disabled or unstable, else one.
// - Live gating-settled drops on mask write, rises when gating matches.
// - Live PLL lock reads one only while locked and selectable.
// - One generic clock control register per output from 0x060 onward.
// - Divide off passes source; on divides by twice (ratio plus one).
// - Generic clock stops while run bit is zero, toggles when one.
// - Kind bit picks oscillator or PLL; index bit picks unit.
// - Slow crystal kept off while its enable is zero.
// - Fuse load sets fuse-done; while set, fuse loads keep the trim.
// - PLL lock rises only after programmed slow clock cycles since write.
`timescale 1ns/1ps
`include "cpes_consts.vh"

module cpes_top #(
  parameter NUM_GCLK      = 5,
  parameter SWITCH_CYCLES = 16,
  parameter MASK_CYCLES   = 8
) (
  // Clock and reset
  input  wire                I_CLK_SYS,
  input  wire                I_ARST_N,
  // Wishbone slave
  input  wire                I_WB_CYC,
  input  wire                I_WB_STB,
  input  wire                I_WB_WE,
  input  wire [7:0]          I_WB_ADR,
  input  wire [3:0]          I_WB_SEL,
  input  wire [31:0]         I_WB_DAT,
  output wire [31:0]         O_WB_DAT,
  output wire                O_WB_ACK,
  // Raw analog and oscillator status
  input  wire                I_BROWNOUT_RAW,
  input  wire                I_XTAL_A_RAW,
  input  wire                I_XTAL_B_RAW,
  input  wire                I_SLOW_XTAL_RAW,
  input  wire                I_PLL_A_RAW,
  input  wire                I_PLL_B_RAW,
  input  wire                I_SLOW_CLK,
  // Generic clock sources: osc a, osc b, pll a, pll b
  input  wire [3:0]          I_GCLK_SRC,
  // Fuse loader, same clock domain
  input  wire                I_FUSE_LOAD,
  input  wire [9:0]          I_FUSE_TRIM,
  // Controls and results
  output wire                O_SLOW_XTAL_ON,
  output wire [31:0]         O_MAIN_CLOCK_CHOICE,
  output wire [31:0]         O_CLOCK_MASK,
  output wire [9:0]          O_RC_TRIM,
  output wire [NUM_GCLK-1:0] O_GCLK,
  output wire                O_IRQ
);

  localparam NSYNC = 11;

  // ================================================================
  // Input synchronisers
  reg  [NSYNC-1:0] sync1_reg;
  reg  [NSYNC-1:0] sync2_reg;
  wire [NSYNC-1:0] raw_in;

  assign raw_in = {I_GCLK_SRC, I_SLOW_CLK, I_PLL_B_RAW, I_PLL_A_RAW,
                   I_SLOW_XTAL_RAW, I_XTAL_B_RAW, I_XTAL_A_RAW, I_BROWNOUT_RAW};

  always @(posedge I_CLK_SYS or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      sync1_reg <= {NSYNC{1'b0}};
      sync2_reg <= {NSYNC{1'b0}};
    end else begin
      sync1_reg <= raw_in;
      sync2_reg <= sync1_reg;
    end
  end

  wire       bod_s    = sync2_reg[0];
  wire       xa_s     = sync2_reg[1];
  wire       xb_s     = sync2_reg[2];
  wire       slow_s   = sync2_reg[3];
  wire [1:0] pll_s    = sync2_reg[5:4];
  wire       sclk_s   = sync2_reg[6];
  wire [3:0] src_s    = sync2_reg[10:7];

  // ================================================================
  // Wishbone decode
  // One wait state: ack rises the cycle after the request and writes
  // take effect on that same edge.
  reg         ack_reg;
  reg  [31:0] rdat_reg;
  wire        req   = I_WB_CYC & I_WB_STB & ~ack_reg;
  wire        wr    = req & I_WB_WE;
  wire [31:0] bmask = {{8{I_WB_SEL[3]}}, {8{I_WB_SEL[2]}},
                       {8{I_WB_SEL[1]}}, {8{I_WB_SEL[0]}}};
  wire [31:0] wdat  = I_WB_DAT & bmask;

  assign O_WB_ACK = ack_reg;
  assign O_WB_DAT = rdat_reg;

  wire wr_main  = wr & (I_WB_ADR == `CPES_OFS_MAIN_CLK);
  wire wr_cmask = wr & (I_WB_ADR == `CPES_OFS_CLK_MASK);
  wire wr_slow  = wr & (I_WB_ADR == `CPES_OFS_SLOW_XTAL);
  wire wr_set   = wr & (I_WB_ADR == `CPES_OFS_EN_SET);
  wire wr_clr   = wr & (I_WB_ADR == `CPES_OFS_EN_CLR);
  wire wr_ack   = wr & (I_WB_ADR == `CPES_OFS_ACK);
  wire wr_trim  = wr & (I_WB_ADR == `CPES_OFS_RC_TRIM);
  wire [1:0] wr_pll;
  assign wr_pll[0] = wr & (I_WB_ADR == `CPES_OFS_PLL_A);
  assign wr_pll[1] = wr & (I_WB_ADR == `CPES_OFS_PLL_B);

  // Merge a byte-lane write into a read/write register.
  function [31:0] merge;
    input [31:0] old;
    input [31:0] rw;
    begin
      merge = ((old & ~bmask) | wdat) & rw;
    end
  endfunction

  // ================================================================
  // Control registers
  reg [31:0] main_reg;
  reg [31:0] cmask_reg;
  reg [31:0] slow_reg;
  reg [31:0] pll_reg [0:1];
  reg [31:0] gclk_reg [0:NUM_GCLK-1];
  integer    g;

  always @(posedge I_CLK_SYS or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      main_reg   <= `CPES_ZERO32;
      cmask_reg  <= `CPES_ZERO32;
      slow_reg   <= `CPES_SLOW_RESET;
      pll_reg[0] <= `CPES_ZERO32;
      pll_reg[1] <= `CPES_ZERO32;
      for (g = 0; g < NUM_GCLK; g = g + 1) begin
        gclk_reg[g] <= `CPES_ZERO32;
      end
    end else begin
      if (wr_main) begin
        main_reg <= merge(main_reg, `CPES_MAIN_RW_BITS);
      end
      if (wr_cmask) begin
        cmask_reg <= merge(cmask_reg, `CPES_MASK_RW_BITS);
      end
      if (wr_slow) begin
        slow_reg <= merge(slow_reg, `CPES_SLOW_RW_BITS);
      end
      if (wr_pll[0]) begin
        pll_reg[0] <= merge(pll_reg[0], `CPES_PLL_RW_BITS);
      end
      if (wr_pll[1]) begin
        pll_reg[1] <= merge(pll_reg[1], `CPES_PLL_RW_BITS);
      end
      for (g = 0; g < NUM_GCLK; g = g + 1) begin
        if (wr && (I_WB_ADR == `CPES_OFS_GCLK_FIRST + g[5:0] * 8'h04)) begin
          gclk_reg[g] <= merge(gclk_reg[g], `CPES_GCLK_RW_BITS);
        end
      end
    end
  end

  assign O_MAIN_CLOCK_CHOICE = main_reg;
  assign O_CLOCK_MASK        = cmask_reg;
  assign O_SLOW_XTAL_ON      = slow_reg[`CPES_SLOW_ON_BIT];

  // ================================================================
  // Clock switch and gating settle timers
  // These stand in for the clock tree handshakes, so the settle time
  // is a fixed count rather than a measured event.
  reg [15:0] sw_cnt_reg;
  reg [15:0] gate_cnt_reg;
  reg        sw_done_reg;
  reg        gate_ok_reg;

  always @(posedge I_CLK_SYS or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      sw_cnt_reg   <= 16'h0000;
      gate_cnt_reg <= 16'h0000;
      sw_done_reg  <= 1'b0;
      gate_ok_reg  <= 1'b0;
    end else begin
      if (wr_main) begin
        sw_cnt_reg  <= 16'h0000;
        sw_done_reg <= 1'b0;
      end else if (!sw_done_reg) begin
        if (sw_cnt_reg >= SWITCH_CYCLES[15:0] - 16'h0001) begin
          sw_done_reg <= 1'b1;
        end else begin
          sw_cnt_reg <= sw_cnt_reg + 16'h0001;
        end
      end
      if (wr_cmask) begin
        gate_cnt_reg <= 16'h0000;
        gate_ok_reg  <= 1'b0;
      end else if (!gate_ok_reg) begin
        if (gate_cnt_reg >= MASK_CYCLES[15:0] - 16'h0001) begin
          gate_ok_reg <= 1'b1;
        end else begin
          gate_cnt_reg <= gate_cnt_reg + 16'h0001;
        end
      end
    end
  end

  // ================================================================
  // PLL lock wait, counted in slow clock rises
  reg        sclk_prev_reg;
  reg [5:0]  lock_cnt_reg [0:1];
  reg [1:0]  lock_wait_done_reg;
  wire       sclk_rise = sclk_s & ~sclk_prev_reg;
  wire [1:0] pll_live;
  integer    p;

  always @(posedge I_CLK_SYS or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      sclk_prev_reg      <= 1'b0;
      lock_cnt_reg[0]    <= 6'h00;
      lock_cnt_reg[1]    <= 6'h00;
      lock_wait_done_reg <= 2'b00;
    end else begin
      sclk_prev_reg <= sclk_s;
      for (p = 0; p < 2; p = p + 1) begin
        if (wr_pll[p] || !pll_reg[p][`CPES_PLL_EN_BIT]) begin
          lock_cnt_reg[p]       <= 6'h00;
          lock_wait_done_reg[p] <= 1'b0;
        end else if (sclk_rise && !lock_wait_done_reg[p]) begin
          if (lock_cnt_reg[p] >= pll_reg[p][`CPES_PLL_CNT_HI:`CPES_PLL_CNT_LO]) begin
            lock_wait_done_reg[p] <= 1'b1;
          end else begin
            lock_cnt_reg[p] <= lock_cnt_reg[p] + 6'h01;
          end
        end
      end
    end
  end

  assign pll_live[0] = pll_s[0] & pll_reg[0][`CPES_PLL_EN_BIT] & lock_wait_done_reg[0];
  assign pll_live[1] = pll_s[1] & pll_reg[1][`CPES_PLL_EN_BIT] & lock_wait_done_reg[1];

  // ================================================================
  // Live status and event flags
  reg  [31:0] live_reg;
  reg  [31:0] live_prev_reg;
  reg  [31:0] mask_reg;
  reg  [31:0] flag_reg;
  reg  [31:0] live_next;
  wire [31:0] rise = live_reg & ~live_prev_reg & `CPES_EVT_BITS;
  wire [31:0] ack_clr;
  wire [31:0] flags_view;

  always @* begin
    live_next = `CPES_ZERO32;
    live_next[`CPES_BIT_BROWNOUT] = bod_s;
    live_next[`CPES_BIT_SLOW]     = slow_s & O_SLOW_XTAL_ON;
    live_next[`CPES_BIT_XTAL_B]   = xb_s;
    live_next[`CPES_BIT_XTAL_A]   = xa_s;
    live_next[`CPES_BIT_GATING]   = gate_ok_reg & ~wr_cmask;
    live_next[`CPES_BIT_SWITCH]   = sw_done_reg & ~wr_main;
    live_next[`CPES_BIT_PLL_B]    = pll_live[1];
    live_next[`CPES_BIT_PLL_A]    = pll_live[0];
  end

  // The switch-done bit is never cleared by acknowledge; it mirrors live.
  assign ack_clr = wr_ack ? (wdat & `CPES_EVT_BITS) : `CPES_ZERO32;

  always @(posedge I_CLK_SYS or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      live_reg      <= `CPES_ZERO32;
      live_prev_reg <= `CPES_ZERO32;
      mask_reg      <= `CPES_ZERO32;
      flag_reg      <= `CPES_ZERO32;
    end else begin
      live_reg      <= live_next;
      live_prev_reg <= live_reg;
      // A set in the same write as a clear leaves the bit set.
      mask_reg <= (mask_reg & ~(wr_clr ? wdat : `CPES_ZERO32))
                  | ((wr_set ? wdat : `CPES_ZERO32) & `CPES_EVT_BITS);
      // An edge arriving with its acknowledge wins over the clear.
      flag_reg <= (flag_reg & ~ack_clr) | rise;
    end
  end

  assign flags_view = {flag_reg[31:`CPES_BIT_SWITCH+1],
                       live_reg[`CPES_BIT_SWITCH],
                       flag_reg[`CPES_BIT_SWITCH-1:0]};
  assign O_IRQ = |(flags_view & mask_reg);

  // ================================================================
  // RC oscillator trim with two-step key
  reg       key_armed_reg;
  reg       fuse_done_reg;
  reg [9:0] trim_reg;
  wire [7:0] key = I_WB_DAT[`CPES_KEY_HI:`CPES_KEY_LO];

  always @(posedge I_CLK_SYS or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      key_armed_reg <= 1'b0;
      fuse_done_reg <= 1'b0;
      trim_reg      <= 10'h000;
    end else begin
      if (wr_trim) begin
        key_armed_reg <= (key == `CPES_KEY_FIRST) && I_WB_SEL[3];
        if (key_armed_reg && key == `CPES_KEY_SECOND && I_WB_SEL[3]) begin
          if (I_WB_SEL[2]) begin
            fuse_done_reg <= I_WB_DAT[`CPES_FUSE_DONE_BIT];
          end
          trim_reg <= (trim_reg & ~bmask[9:0]) | wdat[9:0];
        end
      end else if (I_FUSE_LOAD && !fuse_done_reg) begin
        trim_reg      <= I_FUSE_TRIM;
        fuse_done_reg <= 1'b1;
      end
    end
  end

  assign O_RC_TRIM = trim_reg;

  // ================================================================
  // Read mux and ack
  reg [31:0] rd_mux;
  integer    r;

  always @* begin
    rd_mux = `CPES_ZERO32;
    case (I_WB_ADR)
      `CPES_OFS_MAIN_CLK:  rd_mux = main_reg;
      `CPES_OFS_CLK_MASK:  rd_mux = cmask_reg;
      `CPES_OFS_PLL_A:     rd_mux = pll_reg[0];
      `CPES_OFS_PLL_B:     rd_mux = pll_reg[1];
      `CPES_OFS_SLOW_XTAL: rd_mux = slow_reg;
      `CPES_OFS_EN_MASK:   rd_mux = mask_reg;
      `CPES_OFS_FLAGS:     rd_mux = flags_view;
      `CPES_OFS_LIVE:      rd_mux = live_reg;
      `CPES_OFS_RC_TRIM: begin
        rd_mux[`CPES_FUSE_DONE_BIT]       = fuse_done_reg;
        rd_mux[`CPES_TRIM_HI:`CPES_TRIM_LO] = trim_reg;
      end
      default: begin
        for (r = 0; r < NUM_GCLK; r = r + 1) begin
          if (I_WB_ADR == `CPES_OFS_GCLK_FIRST + r[5:0] * 8'h04) begin
            rd_mux = gclk_reg[r];
          end
        end
      end
    endcase
  end

  always @(posedge I_CLK_SYS or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      ack_reg  <= 1'b0;
      rdat_reg <= `CPES_ZERO32;
    end else begin
      ack_reg  <= req;
      rdat_reg <= (req && !I_WB_WE) ? rd_mux : `CPES_ZERO32;
    end
  end

  // ================================================================
  // Generic clock outputs
  genvar k;
  generate
    for (k = 0; k < NUM_GCLK; k = k + 1) begin : gen_gclk
      cpes_gclk_div u_div (
        .i_clk    (I_CLK_SYS),
        .i_arst_n (I_ARST_N),
        .i_src    (src_s),
        .i_ctrl   (gclk_reg[k]),
        .o_gclk   (O_GCLK[k])
      );
    end
  endgenerate

endmodule
